// >>> bench/dcg_glue_properties.sv
// Concurrent checks on the glue block ports
`timescale 1ns/10ps
module dcg_glue_chk #(
  parameter int DRIVES = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Host side
  input wire logic csN,
  input wire logic dmaAcknowledgeN,
  input wire logic dataOutEnN,
  input wire logic dmaRequest,
  // Engine side
  input wire logic xferNeeded,
  input wire logic regRdStb,
  input wire logic regWrStb,
  input wire logic dmaRdStb,
  input wire logic dmaWrStb,
  input wire logic stepInward,
  input wire logic rwMode,
  // Drive and rate
  input wire logic direction,
  input wire logic [DRIVES-1:0] driveSelN,
  input wire logic filt250OnN,
  input wire logic filt500OnN,
  input wire logic [1:0] rateSel,
  input wire logic [1:0] effRate,
  input wire logic dmaGateBit,
  input wire logic [7:0] precompNs,
  input wire logic [7:0] precompCycles
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // Assertions and cover points
  a_req_gate_on: assert property (xferNeeded && dmaGateBit |=> dmaRequest)
    else $error("dma request missing");
  a_req_gate_off: assert property (!dmaGateBit |=> !dmaRequest)
    else $error("dma request while gate off");
  a_dir_rw_high: assert property (rwMode |=> direction)
    else $error("direction low in read or write");
  a_dir_step: assert property (!rwMode |=> direction == !$past(stepInward))
    else $error("direction wrong");
  a_one_select: assert property ($countones(~driveSelN) <= 1)
    else $error("several drives selected");
  a_filter_rate: assert property ($stable(effRate) [*3] |->
    {filt250OnN, filt500OnN} == (effRate == 2'h1 || effRate == 2'h2 ? 2'h1 : effRate == 2'h0 ? 2'h2 : 2'h3))
    else $error("filter wrong");
  a_precomp_1m: assert property ($stable(effRate) [*3] |-> effRate != 2'h3 || precompNs == 8'h53)
    else $error("precomp wrong at top rate");
  a_precomp_cyc: assert property ($stable(precompNs) [*2] |->
    9'(precompCycles) == (9'(precompNs) + 9'h063) / 9'h064)
    else $error("precomp cycles wrong");
  a_eff_rate: assert property ($stable(rateSel) [*3] |->
    (rateSel == 2'h1 ? effRate inside {2'h1, 2'h2} : effRate == rateSel))
    else $error("effective rate wrong");
  a_bus_idle: assert property ((csN && dmaAcknowledgeN) [*4] |->
    dataOutEnN && !regRdStb && !regWrStb && !dmaRdStb && !dmaWrStb)
    else $error("activity while unselected");
  a_dma_gated: assert property ((!dmaGateBit) [*4] |-> !dmaRdStb && !dmaWrStb)
    else $error("dma strobe while gate off");
  c_dma_read: cover property (dmaRdStb);
  c_reg_write: cover property (regWrStb);
  c_bus_drive: cover property (!dataOutEnN && dmaAcknowledgeN);
endmodule

bind dcg_glue dcg_glue_chk #(.DRIVES(DRIVES)) u_chk (.*);

// >>> bench/dcg_glue_tb.sv
// Self-checking bench for the glue block
`timescale 1ns/10ps
module dcg_glue_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic csN, rdN, wrN, dmaAcknowledgeN, dataOutEnN, dmaRequest, regRdStb, regWrStb, dmaRdStb, dmaWrStb;
  logic xferNeeded = 1'b0, stepInward = 1'b0, rwMode = 1'b0, doorOpenedFlag = 1'b0;
  logic spindleSpeedKind = 1'b1, precompScaledPin = 1'b0;
  logic [2:0] registerAddressLines, regSel;
  logic [7:0] dataIn, dataOut, wrData, precompNs, precompCycles, q;
  logic [7:0] engineRdData = 8'h00;
  logic [1:0] rateSel, effRate;
  logic direction, filt250OnN, filt500OnN, dmaGateBit, enN;
  logic [3:0] driveSelN;
  int nFail = 0, testsRun = 0, cycles = 0, nRd = 0, nWr = 0, nDrd = 0, nDwr = 0;

  dcg_glue #(.DRIVES(4)) uut (.*);
  dcg_host_model host (.*);

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (regRdStb === 1'b1) nRd <= nRd + 1;
    if (regWrStb === 1'b1) nWr <= nWr + 1;
    if (dmaRdStb === 1'b1) nDrd <= nDrd + 1;
    if (dmaWrStb === 1'b1) nDwr <= nDwr + 1;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      nFail++;
      end_sim();
    end
  end
  // ==========================================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    host.cycle(1'b0, 1'b1, 1'b1, a, d, q, enN);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_rates;
    logic [1:0] e;
    logic [7:0] ns;
    for (int k = 0; k < 16; k++) begin
      spindleSpeedKind <= k[2];
      precompScaledPin <= k[3];
      wreg(3'h7, 8'(k[1:0]));
      e = (k[1:0] == 2'h1 && !k[2]) ? 2'h2 : 2'(k[1:0]);
      ns = e == 2'h3 ? 8'h53 : !k[3] ? 8'h7D : e == 2'h0 ? 8'h7D : e == 2'h1 ? 8'hD0 : 8'hFA;
      chk(8'(rateSel), 8'(k[1:0]));
      chk(8'(effRate), 8'(e));
      chk(8'({filt250OnN, filt500OnN}), (e == 2'h1 || e == 2'h2) ? 8'h01 : e == 2'h0 ? 8'h02 : 8'h03);
      chk(precompNs, ns);
      chk(precompCycles, 8'((9'(ns) + 9'h063) / 9'h064));
    end
  endtask
  task automatic t_drive;
    logic [7:0] cmd [4] = '{8'h21, 8'h11, 8'h83, 8'h08};
    logic [3:0] sel [4] = '{4'hD, 4'hF, 4'h7, 4'hF};
    for (int i = 0; i < 4; i++) begin
      wreg(3'h2, cmd[i]);
      chk(8'(driveSelN), 8'(sel[i]));
      chk(8'(dmaGateBit), 8'(cmd[i][3]));
    end
  endtask
  task automatic t_dma;
    wreg(3'h2, 8'h00);
    xferNeeded <= 1'b1;
    engineRdData <= 8'h5A;
    repeat (3) @(posedge core_clk);
    chk(8'(dmaRequest), 8'h00);
    host.cycle(1'b1, 1'b0, 1'b1, 3'h7, 8'h00, q, enN);
    chk({enN, 7'(nDrd)}, 8'h80);
    wreg(3'h2, 8'h08);
    chk(8'(dmaRequest), 8'h01);
    host.cycle(1'b1, 1'b0, 1'b1, 3'h7, 8'h00, q, enN);
    chk({enN, 7'(nDrd)}, 8'h01);
    chk(q, 8'h5A);
    host.cycle(1'b1, 1'b1, 1'b1, 3'h7, 8'h00, q, enN);
    chk({rateSel, 6'(nDwr)}, 8'hC1);
    xferNeeded <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(8'(dmaRequest), 8'h00);
  endtask
  task automatic t_host;
    doorOpenedFlag <= 1'b1;
    engineRdData <= 8'hA5;
    repeat (3) @(posedge core_clk);
    host.cycle(1'b0, 1'b0, 1'b1, 3'h7, 8'h00, q, enN);
    chk(q, 8'h25);
    doorOpenedFlag <= 1'b0;
    repeat (3) @(posedge core_clk);
    host.cycle(1'b0, 1'b0, 1'b1, 3'h7, 8'h00, q, enN);
    chk({q[7], enN, 6'(nRd)}, 8'h80);
    host.cycle(1'b0, 1'b0, 1'b0, 3'h3, 8'h00, q, enN);
    chk({enN, 7'(nRd)}, 8'h80);
    host.cycle(1'b0, 1'b1, 1'b0, 3'h3, 8'h77, q, enN);
    wreg(3'h3, 8'h3C);
    chk({regSel, 5'(nWr)}, 8'h61);
    chk(wrData, 8'h3C);
    host.cycle(1'b0, 1'b0, 1'b1, 3'h3, 8'h00, q, enN);
    chk({q[6:0], 1'(nRd)}, 8'h4B);
  endtask
  task automatic t_dir;
    logic [2:0] pat [3] = '{3'h2, 3'h1, 3'h7};
    for (int i = 0; i < 3; i++) begin
      rwMode <= pat[i][2];
      stepInward <= pat[i][1];
      repeat (3) @(posedge core_clk);
      chk(8'(direction), 8'(pat[i][0]));
    end
    rwMode <= 1'b0;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    chk({dataOutEnN, dmaRequest, direction, dmaGateBit, driveSelN}, 8'hAF);
    chk({rateSel, precompCycles[5:0]}, 8'h02);
    chk(precompNs, 8'h7D);
    rst <= 1'b0;
    t_rates();
    t_drive();
    t_dma();
    t_host();
    t_dir();
    end_sim();
  end
endmodule

// >>> bench/dcg_host_model.sv
// Host bus master model for register and DMA cycles
`timescale 1ns/10ps
module dcg_host_model (
  // Clock
  input wire logic core_clk,
  // Host bus pins
  output logic csN,
  output logic rdN,
  output logic wrN,
  output logic dmaAcknowledgeN,
  output logic [2:0] registerAddressLines,
  output logic [7:0] dataIn,
  // Read return
  input wire logic [7:0] dataOut,
  input wire logic dataOutEnN
);
  initial begin
    csN = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
    dmaAcknowledgeN = 1'b1;
    registerAddressLines = 3'h0;
    dataIn = 8'h00;
  end
  // ==========================================================
  // One bus cycle, strobe low 5 and high 4 cycles
  task automatic cycle(input logic dma, input logic wr, input logic sel, input logic [2:0] a,
                       input logic [7:0] d, output logic [7:0] q, output logic enN);
    @(posedge core_clk);
    csN <= !(sel && !dma);
    dmaAcknowledgeN <= !(sel && dma);
    registerAddressLines <= a;
    dataIn <= d;
    rdN <= wr;
    wrN <= !wr;
    repeat (5) @(posedge core_clk);
    q = dataOut;
    enN = dataOutEnN;
    csN <= 1'b1;
    dmaAcknowledgeN <= 1'b1;
    rdN <= 1'b1;
    wrN <= 1'b1;
    dataIn <= ~d;
    registerAddressLines <= ~a;
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// >>> design/dcg_glue.sv
// Host decode, DMA handshake, rate, filter, precompensation and drive glue
`timescale 1ns/10ps
module dcg_glue #(
  parameter int DRIVES = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Host bus pins
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic dmaAcknowledgeN,
  input wire logic [2:0] registerAddressLines,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOutEnN,
  output logic dmaRequest,
  // Command engine side
  input wire logic xferNeeded,
  input wire logic [7:0] engineRdData,
  output logic [2:0] regSel,
  output logic regRdStb,
  output logic regWrStb,
  output logic dmaRdStb,
  output logic dmaWrStb,
  output logic [7:0] wrData,
  input wire logic stepInward,
  input wire logic rwMode,
  // Drive and configuration pins
  input wire logic spindleSpeedKind,
  input wire logic precompScaledPin,
  input wire logic doorOpenedFlag,
  output logic direction,
  output logic [DRIVES-1:0] driveSelN,
  output logic filt250OnN,
  output logic filt500OnN,
  // Rate, DMA gate and precompensation results
  output logic [1:0] rateSel,
  output logic [1:0] effRate,
  output logic dmaGateBit,
  output logic [7:0] precompNs,
  output logic [7:0] precompCycles
);
  if (DRIVES < 1 || DRIVES > 4) begin : g_bad_drives
    $error("DRIVES must be 1 to 4");
  end

  typedef struct packed {
    logic [7:0] driveCtrl;
    dcg_pkg::dcg_rate_type rate;
    logic [1:0] strobePrev;
    logic doorLatch;
    logic [7:0] dataOut;
    logic dataOutEnN;
    logic dmaRequest;
    logic [2:0] regSel;
    logic regRdStb;
    logic regWrStb;
    logic dmaRdStb;
    logic dmaWrStb;
    logic [7:0] wrData;
    logic direction;
    logic [3:0] driveSelN;
    logic filt250OnN;
    logic filt500OnN;
    dcg_pkg::dcg_rate_type effRate;
    logic [7:0] precompNs;
    logic [7:0] precompCycles;
  } dcg_state_type;

  dcg_state_type state_r;
  dcg_state_type state_nxt;

  // ==========================================================
  // Pin synchronisers
  logic csSync;
  logic rdSync;
  logic wrSync;
  logic dakSync;
  logic spindleSync;
  logic scaledSync;
  logic doorSync;
  logic [2:0] addrSync;
  logic [7:0] dataSync;

  dcg_sync #(.WIDTH(4), .INIT(4'hF)) syncStrobes (
    .core_clk(core_clk),
    .rst(rst),
    .pinIn({csN, rdN, wrN, dmaAcknowledgeN}),
    .syncOut({csSync, rdSync, wrSync, dakSync})
  );

  dcg_sync #(.WIDTH(14), .INIT(14'h0000)) syncLevels (
    .core_clk(core_clk),
    .rst(rst),
    .pinIn({spindleSpeedKind, precompScaledPin, doorOpenedFlag, registerAddressLines, dataIn}),
    .syncOut({spindleSync, scaledSync, doorSync, addrSync, dataSync})
  );

  // ==========================================================
  // Drive select decode per drive
  logic [3:0] selHit;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_drv
      if (gi < DRIVES) begin : g_on
        // [R15] Select gated by motor
        assign selHit[gi] = (state_r.driveCtrl[dcg_pkg::DC_SEL_LSB +: dcg_pkg::DC_SEL_W] == 2'(gi))
          && state_r.driveCtrl[dcg_pkg::DC_MOTOR_LSB + gi];
      end else begin : g_off
        assign selHit[gi] = 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // Next state
  logic hostSel;
  logic dmaSel;
  logic rdLow;
  logic wrFall;
  logic rdFall;
  logic gate;
  dcg_pkg::dcg_rate_type eff;

  always_comb begin
    state_nxt = state_r;
    gate = state_r.driveCtrl[dcg_pkg::DC_DMA_GATE_BIT];
    // [R7] Select qualifies strobes
    hostSel = !csSync;
    // [R9] Gated acknowledge qualifies strobes
    dmaSel = !dakSync && gate && !hostSel;
    rdLow = !rdSync;
    rdFall = state_r.strobePrev[1] && !rdSync;
    wrFall = state_r.strobePrev[0] && !wrSync;
    state_nxt.strobePrev = {rdSync, wrSync};
    state_nxt.regRdStb = 1'b0;
    state_nxt.regWrStb = 1'b0;
    state_nxt.dmaRdStb = 1'b0;
    state_nxt.dmaWrStb = 1'b0;
    // [R16] Latch door input
    state_nxt.doorLatch = doorSync;

    // [R6] Address picks register
    if (hostSel && wrFall) begin
      state_nxt.regSel = addrSync;
      state_nxt.wrData = dataSync;
      if (addrSync == dcg_pkg::ADDR_DRIVE_CTRL) begin
        state_nxt.driveCtrl = dataSync;
      end else if (addrSync == dcg_pkg::ADDR_RATE) begin
        // [R4] Rate register write
        state_nxt.rate = dcg_pkg::dcg_rate_type'(dataSync[dcg_pkg::RATE_LSB +: 2]);
      end else begin
        state_nxt.regWrStb = 1'b1;
      end
    end else if (dmaSel && wrFall) begin
      // [R6] Address ignored in DMA
      state_nxt.wrData = dataSync;
      state_nxt.dmaWrStb = 1'b1;
    end
    if (hostSel && rdFall) begin
      state_nxt.regSel = addrSync;
      state_nxt.regRdStb = (addrSync != dcg_pkg::ADDR_DOOR);
    end else if (dmaSel && rdFall) begin
      state_nxt.dmaRdStb = 1'b1;
    end

    // [R17] Drive bus only when selected
    state_nxt.dataOutEnN = !((hostSel || dmaSel) && rdLow);
    state_nxt.dataOut = engineRdData;
    if (hostSel && addrSync == dcg_pkg::ADDR_DOOR) begin
      // [R16] Inverted door flag
      state_nxt.dataOut[dcg_pkg::DOOR_BIT] = !state_r.doorLatch;
    end

    // [R10] Request gated by bit
    state_nxt.dmaRequest = xferNeeded && gate;

    // [R11] Step direction level
    state_nxt.direction = !stepInward;
    // [R12] High in read/write
    if (rwMode) begin
      state_nxt.direction = 1'b1;
    end

    state_nxt.driveSelN = ~selHit;

    // [R13] Low spindle remaps 300
    eff = state_r.rate;
    if (state_r.rate == dcg_pkg::DCG_RATE_300K && !spindleSync) begin
      eff = dcg_pkg::DCG_RATE_250K;
    end
    // [R14] High spindle keeps 300
    state_nxt.effRate = eff;

    // [R5] Filter from rate
    state_nxt.filt250OnN = !(eff == dcg_pkg::DCG_RATE_250K || eff == dcg_pkg::DCG_RATE_300K);
    state_nxt.filt500OnN = !(eff == dcg_pkg::DCG_RATE_500K);

    // [R3] Mode from pin
    if (scaledSync) begin
      // [R2] Scaled shift by rate
      case (eff)
        dcg_pkg::DCG_RATE_1M: begin
          state_nxt.precompNs = 8'(dcg_pkg::PC_1M_NS);
          state_nxt.precompCycles = dcg_pkg::PC_1M_CYC;
        end
        dcg_pkg::DCG_RATE_500K: begin
          state_nxt.precompNs = 8'(dcg_pkg::PC_500K_NS);
          state_nxt.precompCycles = dcg_pkg::PC_500K_CYC;
        end
        dcg_pkg::DCG_RATE_300K: begin
          state_nxt.precompNs = 8'(dcg_pkg::PC_300K_NS);
          state_nxt.precompCycles = dcg_pkg::PC_300K_CYC;
        end
        default: begin
          state_nxt.precompNs = 8'(dcg_pkg::PC_250K_NS);
          state_nxt.precompCycles = dcg_pkg::PC_250K_CYC;
        end
      endcase
    end else if (eff == dcg_pkg::DCG_RATE_1M) begin
      // [R1] Fixed shift at 1 Mb/s
      state_nxt.precompNs = 8'(dcg_pkg::PC_1M_NS);
      state_nxt.precompCycles = dcg_pkg::PC_1M_CYC;
    end else begin
      // [R1] Fixed shift other rates
      state_nxt.precompNs = 8'(dcg_pkg::PC_FIXED_NS);
      state_nxt.precompCycles = dcg_pkg::PC_FIXED_CYC;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= '0;
      state_r.driveCtrl <= dcg_pkg::DRIVE_CTRL_RESET;
      state_r.rate <= dcg_pkg::RATE_RESET;
      state_r.strobePrev <= 2'h3;
      state_r.dataOutEnN <= 1'b1;
      state_r.direction <= 1'b1;
      state_r.driveSelN <= 4'hF;
      state_r.filt250OnN <= 1'b1;
      state_r.filt500OnN <= 1'b1;
      state_r.effRate <= dcg_pkg::RATE_RESET;
      state_r.precompNs <= 8'(dcg_pkg::PC_FIXED_NS);
      state_r.precompCycles <= dcg_pkg::PC_FIXED_CYC;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign dataOut = state_r.dataOut;
  assign dataOutEnN = state_r.dataOutEnN;
  assign dmaRequest = state_r.dmaRequest;
  assign regSel = state_r.regSel;
  assign regRdStb = state_r.regRdStb;
  assign regWrStb = state_r.regWrStb;
  assign dmaRdStb = state_r.dmaRdStb;
  assign dmaWrStb = state_r.dmaWrStb;
  assign wrData = state_r.wrData;
  assign direction = state_r.direction;
  assign driveSelN = state_r.driveSelN[DRIVES-1:0];
  assign filt250OnN = state_r.filt250OnN;
  assign filt500OnN = state_r.filt500OnN;
  assign rateSel = state_r.rate;
  assign effRate = state_r.effRate;
  assign dmaGateBit = state_r.driveCtrl[dcg_pkg::DC_DMA_GATE_BIT];
  assign precompNs = state_r.precompNs;
  assign precompCycles = state_r.precompCycles;
endmodule

// >>> design/dcg_pkg.sv
// Constants and types of the disk controller host and drive glue
// Contract
// [R1] Fixed mode: 125 ns, 83 ns at 1 Mb/s
// [R2] Scaled mode: 83/125/208/250 ns by rate
// [R3] Configuration pin picks fixed or scaled mode
// [R4] Data-rate register: 250/300/500 kb/s plus 1 Mb/s
// [R5] Loop filter switched in from selected rate
// [R6] Address lines pick register, ignored during DMA
// [R7] Strobes accepted for registers only with select
// [R8] Host keeps chip select high during DMA
// [R9] DMA acknowledge qualifies strobes when gate set
// [R10] DMA request output enabled by gate bit
// [R11] Direction low steps in, high steps out
// [R12] Direction held high in read/write mode
// [R13] Low spindle kind turns 300 into 250
// [R14] High spindle kind keeps true 300 kb/s
// [R15] Drive select low only with matching motor
// [R16] Latched inverted door flag on D7 at 7
// [R17] Bus undriven, strobes ignored when unselected
package dcg_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [2:0] ADDR_DRIVE_CTRL = 3'h2;
  localparam logic [2:0] ADDR_RATE = 3'h7;
  localparam logic [2:0] ADDR_DOOR = 3'h7;

  // ==========================================================
  // Drive control, door and rate field layout
  localparam int DC_SEL_LSB = 0;
  localparam int DC_SEL_W = 2;
  localparam int DC_DMA_GATE_BIT = 3;
  localparam int DC_MOTOR_LSB = 4;
  localparam int DOOR_BIT = 7;
  localparam int RATE_LSB = 0;
  localparam logic [7:0] DRIVE_CTRL_RESET = 8'h00;

  // ==========================================================
  // Data rate codes
  typedef enum logic [1:0] {
    DCG_RATE_500K = 2'h0,
    DCG_RATE_300K = 2'h1,
    DCG_RATE_250K = 2'h2,
    DCG_RATE_1M = 2'h3
  } dcg_rate_type;
  localparam dcg_rate_type RATE_RESET = DCG_RATE_500K;

  // ==========================================================
  // Precompensation timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int PC_1M_NS = 83;
  localparam int PC_500K_NS = 125;
  localparam int PC_300K_NS = 208;
  localparam int PC_250K_NS = 250;
  localparam int PC_FIXED_NS = 125;
  localparam logic [7:0] PC_1M_CYC = 8'((PC_1M_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PC_500K_CYC = 8'((PC_500K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PC_300K_CYC = 8'((PC_300K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PC_250K_CYC = 8'((PC_250K_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PC_FIXED_CYC = 8'((PC_FIXED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// >>> design/dcg_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module dcg_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pin side and synchronised side
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_r;

  // ==========================================================
  // First stage read only by second stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_r <= INIT;
      syncOut <= INIT;
    end else begin
      meta_r <= pinIn;
      syncOut <= meta_r;
    end
  end
endmodule
